// ===== rtl/cic_irq_ctrl.sv
// Interrupt controller of the processor core with APB register access
//
// Function
// - Any reset leaves every interrupt enable cleared.
// - Vector only when global enable and the source enable are both set.
// - Peripheral-group sources also need the peripheral-group enable.
// - Core-level sources vector without the peripheral-group enable.
// - A flag sets on its event regardless of any enable.
// - Taking an interrupt flushes the prefetched instruction and clears global enable.
// - Taking an interrupt pushes the current program counter on the return stack.
// - Taking an interrupt copies core context into shadow registers by hardware.
// - Shadow covers working, status except timeout/powerdown, bank, pointers, pc high.
// - After saving context the program counter loads the fixed vector.
// - With global enable clear, events set flags but never redirect.
// - Return instruction pops the stack, restores shadows, sets global enable.
// - An enabled event seen while disabled is served once enabled again.
// - Requests are sampled in the first phase of each instruction cycle.
// - Latency to the vector depends on the instruction executing at detection.
//
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/1ns
module cic_irq_ctrl #(
  parameter int unsigned NPER = 7,
  parameter int unsigned STACK_DEPTH = 16,
  parameter int unsigned PC_W = 15
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RESET,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Event sources, one-cycle pulses on REF_CLK
  input wire logic [7:0] CORE_EVENT,
  input wire logic [NPER*8-1:0] PER_EVENT,
  // Processor core
  input wire logic INSTR_END,
  input wire logic RETURN_INSTR,
  input wire logic [PC_W-1:0] CORE_PC,
  input wire cic_pkg::cic_ctx_type CORE_CTX,
  output logic Q1_STROBE,
  output logic FLUSH,
  output logic PC_LOAD,
  output logic [PC_W-1:0] PC_VALUE,
  output logic CTX_RESTORE,
  output cic_pkg::cic_ctx_type CTX_VALUE,
  // Monitor interrupt
  output logic MON_IRQ
);

  localparam int unsigned SP_W = $clog2(STACK_DEPTH + 1);

  if (NPER < 1 || NPER > 8 || STACK_DEPTH < 1 || PC_W < 3 || PC_W > 16 ||
      cic_pkg::CLKS_PER_INSTR != 4)
  begin : g_param_check
    $error("cic_irq_ctrl: unsupported parameter values");
  end

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    cic_pkg::cic_state_type st;
    logic [1:0] phase;
    logic global_irq_enable;
    logic peripheral_group_irq_enable;
    logic [7:0] core_en;
    logic [7:0] core_flag;
    logic [NPER-1:0][7:0] per_en;
    logic [NPER-1:0][7:0] per_flag;
    logic req;
    logic [STACK_DEPTH-1:0][PC_W-1:0] stack;
    logic [SP_W-1:0] sp;
    cic_pkg::cic_ctx_type shadow;
    logic [PC_W-1:0] pc_out;
    cic_pkg::cic_ctx_type ctx_out;
    logic [cic_pkg::MON_W-1:0] mon_stat;
    logic [cic_pkg::MON_W-1:0] mon_mask;
    logic [31:0] prdata;
    logic pslverr;
  } cic_regs_type;

  cic_regs_type r_r;
  cic_regs_type r_nxt;
  logic q1;
  logic core_hit;
  logic per_hit;
  logic pending;
  logic take;

  assign q1 = (r_r.phase == cic_pkg::Q1_PHASE);
  assign core_hit = |(r_r.core_flag & r_r.core_en);
  assign per_hit = |(r_r.per_flag & r_r.per_en);
  assign pending = r_r.global_irq_enable
    & (core_hit | (r_r.peripheral_group_irq_enable & per_hit));
  assign take = (r_r.st == cic_pkg::ST_RUN) & ~RETURN_INSTR & INSTR_END & r_r.req
    & r_r.global_irq_enable;

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb
  begin
    logic setup;
    logic hit;
    logic [31:0] rd;
    logic [7:0] wb;
    setup = PSEL & ~PENABLE;
    hit = 1'b1;
    rd = 32'h0000_0000;
    wb = PWDATA[7:0];
    r_nxt = r_r;
    r_nxt.phase = r_r.phase + 2'h1;
    // Sample the request only in the first phase of the instruction cycle
    if (q1)
    begin
      r_nxt.req = pending;
    end
    // Read decode in setup phase so read data comes from a flop
    if (PADDR == cic_pkg::ADDR_CTRL)
    begin
      rd[cic_pkg::CTRL_GLOBAL_EN_POS] = r_r.global_irq_enable;
      rd[cic_pkg::CTRL_GROUP_EN_POS] = r_r.peripheral_group_irq_enable;
      rd[cic_pkg::CTRL_PEND_POS] = core_hit | (r_r.peripheral_group_irq_enable & per_hit);
    end
    else if (PADDR == cic_pkg::ADDR_CORE_EN)
    begin
      rd[7:0] = r_r.core_en;
    end
    else if (PADDR == cic_pkg::ADDR_CORE_FLAG)
    begin
      rd[7:0] = r_r.core_flag;
    end
    else if (PADDR == cic_pkg::ADDR_MON_STAT)
    begin
      rd[cic_pkg::MON_W-1:0] = r_r.mon_stat;
    end
    else if (PADDR == cic_pkg::ADDR_MON_MASK)
    begin
      rd[cic_pkg::MON_W-1:0] = r_r.mon_mask;
    end
    else
    begin
      hit = 1'b0;
      for (int i = 0; i < NPER; i++)
      begin
        if (PADDR == cic_pkg::ADDR_PER_EN_BASE + 8'(4 * i))
        begin
          hit = 1'b1;
          rd[7:0] = r_r.per_en[i];
        end
        if (PADDR == cic_pkg::ADDR_PER_FLAG_BASE + 8'(4 * i))
        begin
          hit = 1'b1;
          rd[7:0] = r_r.per_flag[i];
        end
      end
    end
    if (setup)
    begin
      r_nxt.prdata = hit ? rd : 32'h0000_0000;
      r_nxt.pslverr = ~hit;
    end
    // Writes take effect in the access phase; flags clear by writing ones
    if (PSEL & PENABLE & PWRITE & ~r_r.pslverr)
    begin
      if (PADDR == cic_pkg::ADDR_CTRL)
      begin
        r_nxt.global_irq_enable = wb[cic_pkg::CTRL_GLOBAL_EN_POS];
        r_nxt.peripheral_group_irq_enable = wb[cic_pkg::CTRL_GROUP_EN_POS];
      end
      else if (PADDR == cic_pkg::ADDR_CORE_EN)
      begin
        r_nxt.core_en = wb;
      end
      else if (PADDR == cic_pkg::ADDR_CORE_FLAG)
      begin
        r_nxt.core_flag = r_r.core_flag & ~wb;
      end
      else if (PADDR == cic_pkg::ADDR_MON_STAT)
      begin
        r_nxt.mon_stat = r_r.mon_stat & ~wb[cic_pkg::MON_W-1:0];
      end
      else if (PADDR == cic_pkg::ADDR_MON_MASK)
      begin
        r_nxt.mon_mask = wb[cic_pkg::MON_W-1:0];
      end
      else
      begin
        for (int i = 0; i < NPER; i++)
        begin
          if (PADDR == cic_pkg::ADDR_PER_EN_BASE + 8'(4 * i))
          begin
            r_nxt.per_en[i] = wb;
          end
          if (PADDR == cic_pkg::ADDR_PER_FLAG_BASE + 8'(4 * i))
          begin
            r_nxt.per_flag[i] = r_r.per_flag[i] & ~wb;
          end
        end
      end
    end
    // Events set flags after the clear, so a same-cycle event is kept
    r_nxt.core_flag = r_nxt.core_flag | CORE_EVENT;
    r_nxt.per_flag = r_nxt.per_flag | PER_EVENT;
    // Entry and return sequencing
    case (r_r.st)
      cic_pkg::ST_RUN:
      begin
        if (RETURN_INSTR)
        begin
          if (r_r.sp != '0)
          begin
            r_nxt.sp = r_r.sp - SP_W'(1);
            r_nxt.pc_out = r_r.stack[r_r.sp - SP_W'(1)];
          end
          else
          begin
            r_nxt.mon_stat[cic_pkg::MON_UNDERFLOW_POS] = 1'b1;
          end
          r_nxt.ctx_out = r_r.shadow;
          r_nxt.ctx_out.status[cic_pkg::STAT_TIMEOUT_POS] =
            CORE_CTX.status[cic_pkg::STAT_TIMEOUT_POS];
          r_nxt.ctx_out.status[cic_pkg::STAT_POWERDOWN_POS] =
            CORE_CTX.status[cic_pkg::STAT_POWERDOWN_POS];
          r_nxt.global_irq_enable = 1'b1;
          r_nxt.mon_stat[cic_pkg::MON_RETURN_POS] = 1'b1;
          r_nxt.st = cic_pkg::ST_LEAVE;
        end
        else if (take)
        begin
          r_nxt.global_irq_enable = 1'b0;
          r_nxt.req = 1'b0;
          if (r_r.sp < SP_W'(STACK_DEPTH))
          begin
            r_nxt.stack[r_r.sp] = CORE_PC;
            r_nxt.sp = r_r.sp + SP_W'(1);
          end
          else
          begin
            r_nxt.mon_stat[cic_pkg::MON_OVERFLOW_POS] = 1'b1;
          end
          r_nxt.shadow = CORE_CTX;
          r_nxt.pc_out = PC_W'(cic_pkg::IRQ_VECTOR);
          r_nxt.mon_stat[cic_pkg::MON_TAKEN_POS] = 1'b1;
          r_nxt.st = cic_pkg::ST_ENTER;
        end
      end
      default:
      begin
        r_nxt.st = cic_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      r_r <= '0;
      r_r.st <= cic_pkg::ST_RUN;
    end
    else
    begin
      r_r <= r_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign PRDATA = r_r.prdata;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & r_r.pslverr;
  assign Q1_STROBE = q1;
  assign FLUSH = (r_r.st == cic_pkg::ST_ENTER);
  assign PC_LOAD = (r_r.st == cic_pkg::ST_ENTER) | (r_r.st == cic_pkg::ST_LEAVE);
  assign PC_VALUE = r_r.pc_out;
  assign CTX_RESTORE = (r_r.st == cic_pkg::ST_LEAVE);
  assign CTX_VALUE = r_r.ctx_out;
  assign MON_IRQ = |(r_r.mon_stat & r_r.mon_mask);

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);

  sequence s_take;
    take;
  endsequence

  sequence s_return;
    (r_r.st == cic_pkg::ST_RUN) && RETURN_INSTR;
  endsequence

  reset_clears_en_a: assert property ($past(RESET) |-> !r_r.global_irq_enable
    && !r_r.peripheral_group_irq_enable && r_r.core_en == 8'h00)
    else $error("enables not clear after reset");
  flush_needs_en_a: assert property (FLUSH |-> $past(r_r.global_irq_enable)
    && $past(r_r.req)) else $error("vector without global enable");
  group_gate_a: assert property ((q1 && r_r.global_irq_enable && !core_hit && per_hit
    && !r_r.peripheral_group_irq_enable) |=> !r_r.req)
    else $error("peripheral source taken without group enable");
  core_bypass_a: assert property ((q1 && !take && r_r.global_irq_enable && core_hit
    && !r_r.peripheral_group_irq_enable) |=> r_r.req)
    else $error("core source blocked by group enable");
  flag_set_a: assert property ((CORE_EVENT != 8'h00) |=>
    (r_r.core_flag & $past(CORE_EVENT)) == $past(CORE_EVENT))
    else $error("event flag not set");
  entry_seq_a: assert property (s_take |=> FLUSH && PC_LOAD
    && !r_r.global_irq_enable && PC_VALUE == PC_W'(cic_pkg::IRQ_VECTOR)
    && r_r.shadow == $past(CORE_CTX) ##1 !FLUSH && !PC_LOAD)
    else $error("interrupt entry sequence wrong");
  push_pc_a: assert property ((s_take and (r_r.sp < SP_W'(STACK_DEPTH))) |=>
    r_r.sp == $past(r_r.sp) + SP_W'(1) && r_r.stack[$past(r_r.sp)] == $past(CORE_PC))
    else $error("return address not pushed");
  no_redirect_a: assert property ((!r_r.global_irq_enable && r_r.st == cic_pkg::ST_RUN)
    |=> !FLUSH) else $error("redirect while globally disabled");
  return_seq_a: assert property (s_return |=> CTX_RESTORE && PC_LOAD
    && r_r.global_irq_enable && CTX_VALUE.w == $past(r_r.shadow.w)
    && CTX_VALUE.indirect_pointer_regs == $past(r_r.shadow.indirect_pointer_regs)
    && CTX_VALUE.status[cic_pkg::STAT_TIMEOUT_POS]
    == $past(CORE_CTX.status[cic_pkg::STAT_TIMEOUT_POS]))
    else $error("return restore wrong");
  pending_kept_a: assert property ((q1 && pending) |=> r_r.req || FLUSH)
    else $error("pending request lost");
  q1_sample_a: assert property ((!q1 && !take) |=> $stable(r_r.req))
    else $error("request sampled outside first phase");
  take_at_end_a: assert property (FLUSH |-> $past(INSTR_END))
    else $error("entry not at instruction boundary");

endmodule : cic_irq_ctrl

// ===== rtl/cic_pkg.sv
// Constants and carrier types of the processor interrupt controller
package cic_pkg;

  // ------------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CORE_EN = 8'h04;
  localparam logic [7:0] ADDR_CORE_FLAG = 8'h08;
  localparam logic [7:0] ADDR_MON_STAT = 8'h0c;
  localparam logic [7:0] ADDR_MON_MASK = 8'h10;
  localparam logic [7:0] ADDR_PER_EN_BASE = 8'h20;
  localparam logic [7:0] ADDR_PER_FLAG_BASE = 8'h40;

  // ------------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------------
  localparam int unsigned CTRL_GLOBAL_EN_POS = 7;
  localparam int unsigned CTRL_GROUP_EN_POS = 6;
  localparam int unsigned CTRL_PEND_POS = 0;
  localparam int unsigned STAT_TIMEOUT_POS = 4;
  localparam int unsigned STAT_POWERDOWN_POS = 3;
  localparam int unsigned MON_TAKEN_POS = 0;
  localparam int unsigned MON_RETURN_POS = 1;
  localparam int unsigned MON_OVERFLOW_POS = 2;
  localparam int unsigned MON_UNDERFLOW_POS = 3;
  localparam int unsigned MON_W = 4;
  localparam logic [7:0] ENABLE_RST = 8'h00;
  localparam logic [3:0] MON_MASK_RST = 4'h0;

  // ------------------------------------------------------------------
  // Core timing and vector
  // ------------------------------------------------------------------
  localparam int unsigned CLKS_PER_INSTR = 4;
  localparam logic [1:0] Q1_PHASE = 2'h0;
  localparam logic [15:0] IRQ_VECTOR = 16'h0004;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] w;
    logic [7:0] status;
    logic [7:0] bank_select_reg;
    logic [1:0][15:0] indirect_pointer_regs;
    logic [7:0] pc_high_latch;
  } cic_ctx_type;

  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_ENTER = 3'b010,
    ST_LEAVE = 3'b100
  } cic_state_type;

endpackage : cic_pkg

// ===== tb/cic_core_model.sv
// Behavioural processor core facing the interrupt controller
`timescale 1ns/1ns
module cic_core_model #(
  parameter int unsigned PC_W = 15
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bench control: instruction length minus one, return request
  input wire logic [3:0] instr_len,
  input wire logic ret_req,
  // Controller side
  input wire logic pc_load,
  input wire logic [PC_W-1:0] pc_value,
  input wire logic ctx_restore,
  input wire cic_pkg::cic_ctx_type ctx_value,
  output logic instr_end,
  output logic return_instr,
  output logic [PC_W-1:0] core_pc,
  output cic_pkg::cic_ctx_type core_ctx
);
  logic [3:0] cnt_r;
  logic ret_pend_r;

  assign instr_end = (cnt_r >= instr_len);
  assign return_instr = ret_pend_r & instr_end;

  // Handler clobbers the context on entry so a restore is visible
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_r <= 4'h0;
      ret_pend_r <= 1'b0;
      core_pc <= PC_W'(16'h0123);
      core_ctx <= 64'h3c5a_7e01_2345_6789;
    end
    else
    begin
      cnt_r <= instr_end ? 4'h0 : cnt_r + 4'h1;
      if (ret_req)
        ret_pend_r <= 1'b1;
      else if (instr_end)
        ret_pend_r <= 1'b0;
      if (pc_load)
        core_pc <= pc_value;
      else if (instr_end)
        core_pc <= core_pc + 1'b1;
      if (ctx_restore)
        core_ctx <= ctx_value;
      else if (pc_load)
        core_ctx <= ~core_ctx;
    end
  end
endmodule : cic_core_model

// ===== tb/tb_cpu_interrupt_controller.sv
// Self-checking bench of the processor interrupt controller
`timescale 1ns/1ns
`define CHK(nm, e, a) \
  begin compares++; if ((a) !== (e)) begin n_errors++; \
  $display("BAD %s exp=%h got=%h", nm, e, a); end end
module tb_cpu_interrupt_controller;
  localparam int unsigned NP = 2;
  logic clk = 1'b0;
  logic rst, psel, penable, pwrite, pready, pslverr, re;
  logic [7:0] paddr, core_ev;
  logic [31:0] pwdata, prdata, rq;
  logic [NP*8-1:0] per_ev;
  logic instr_end, ret_instr, ret_req, q1, flush, pc_load, ctx_rst, mon_irq;
  logic [3:0] ilen;
  logic [14:0] core_pc, pc_val, last_pc, sv_pc;
  cic_pkg::cic_ctx_type core_ctx, ctx_val, last_ctx, sv_ctx, exp_ctx;
  int n_errors = 0;
  int compares = 0;
  int n_flush = 0;

  always #5 clk = ~clk;

  cic_irq_ctrl #(.NPER(NP), .STACK_DEPTH(16), .PC_W(15)) uut (
    .REF_CLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CORE_EVENT(core_ev), .PER_EVENT(per_ev), .INSTR_END(instr_end),
    .RETURN_INSTR(ret_instr), .CORE_PC(core_pc), .CORE_CTX(core_ctx), .Q1_STROBE(q1),
    .FLUSH(flush), .PC_LOAD(pc_load), .PC_VALUE(pc_val), .CTX_RESTORE(ctx_rst),
    .CTX_VALUE(ctx_val), .MON_IRQ(mon_irq));

  cic_core_model #(.PC_W(15)) core (
    .clk(clk), .rst(rst), .instr_len(ilen), .ret_req(ret_req), .pc_load(pc_load),
    .pc_value(pc_val), .ctx_restore(ctx_rst), .ctx_value(ctx_val), .instr_end(instr_end),
    .return_instr(ret_instr), .core_pc(core_pc), .core_ctx(core_ctx));

  // Remember what the core showed at the last instruction boundary
  always @(posedge clk)
  begin
    if (instr_end)
    begin
      last_pc <= core_pc;
      last_ctx <= core_ctx;
    end
    if (flush === 1'b1)
      n_flush <= n_flush + 1;
  end

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task tally_and_finish;
    if (n_errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    if (i == 20)
    begin
      n_errors++;
      tally_and_finish();
    end
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Let the write settle so callers see the updated outputs
    #1;
  endtask : apb

  task ev(input logic [7:0] c, input logic [NP*8-1:0] p);
    @(posedge clk);
    core_ev <= c;
    per_ev <= p;
    @(posedge clk);
    core_ev <= 8'h00;
    per_ev <= '0;
  endtask : ev

  // Waits for a one-cycle output pulse, bounded
  task wait_pulse(input bit on_ret);
    int i;
    for (i = 0; i < 80; i++)
    begin
      @(posedge clk);
      #1;
      if ((on_ret ? ctx_rst : flush) === 1'b1)
        break;
    end
    if (i == 80)
    begin
      n_errors++;
      tally_and_finish();
    end
    `CHK("pc load", 1'b1, pc_load)
  endtask : wait_pulse

  task take;
    wait_pulse(1'b0);
    sv_pc = last_pc;
    sv_ctx = last_ctx;
    `CHK("vector", cic_pkg::IRQ_VECTOR[14:0], pc_val)
  endtask : take

  task ret;
    @(posedge clk);
    ret_req <= 1'b1;
    @(posedge clk);
    ret_req <= 1'b0;
    exp_ctx = sv_ctx;
    exp_ctx.status[cic_pkg::STAT_TIMEOUT_POS] = ~sv_ctx.status[cic_pkg::STAT_TIMEOUT_POS];
    exp_ctx.status[cic_pkg::STAT_POWERDOWN_POS] = ~sv_ctx.status[cic_pkg::STAT_POWERDOWN_POS];
    wait_pulse(1'b1);
    `CHK("return pc", sv_pc, pc_val)
    `CHK("context", exp_ctx, ctx_val)
  endtask : ret

  task no_take;
    int k;
    k = n_flush;
    repeat (30) @(posedge clk);
    `CHK("no take", k, n_flush)
  endtask : no_take

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial
  begin
    int n;
    rst = 1'b1;
    {psel, penable, pwrite, ret_req} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    core_ev = 8'h00;
    per_ev = '0;
    ilen = 4'h3;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, cic_pkg::ADDR_CTRL, 32'h0);
    `CHK("ctrl reset", 32'h0, rq)
    apb(1'b0, cic_pkg::ADDR_CORE_EN, 32'h0);
    `CHK("core en reset", 32'h0, rq)
    apb(1'b0, cic_pkg::ADDR_PER_EN_BASE, 32'h0);
    `CHK("per en reset", 32'h0, rq)
    n = 0;
    repeat (8)
    begin
      @(posedge clk);
      #1;
      n += int'(q1 === 1'b1);
    end
    `CHK("first phase", 2, n)
    ev(8'h04, '0);
    apb(1'b0, cic_pkg::ADDR_CORE_FLAG, 32'h0);
    `CHK("core flag", 32'h04, rq)
    apb(1'b1, cic_pkg::ADDR_CORE_EN, 32'h04);
    no_take();
    apb(1'b1, cic_pkg::ADDR_CTRL, 32'h80);
    take();
    apb(1'b0, cic_pkg::ADDR_CTRL, 32'h0);
    `CHK("global enable", 1'b0, rq[7])
    apb(1'b1, cic_pkg::ADDR_MON_MASK, 32'h01);
    `CHK("irq raised", 1'b1, mon_irq)
    apb(1'b1, cic_pkg::ADDR_MON_MASK, 32'h00);
    `CHK("irq masked", 1'b0, mon_irq)
    apb(1'b1, cic_pkg::ADDR_MON_MASK, 32'h01);
    apb(1'b1, cic_pkg::ADDR_MON_STAT, 32'h01);
    `CHK("irq cleared", 1'b0, mon_irq)
    ev(8'h01, 16'h0001);
    apb(1'b0, cic_pkg::ADDR_PER_FLAG_BASE, 32'h0);
    `CHK("per flag", 32'h01, rq)
    apb(1'b1, cic_pkg::ADDR_PER_EN_BASE, 32'h01);
    no_take();
    apb(1'b1, cic_pkg::ADDR_CORE_FLAG, 32'h04);
    ret();
    apb(1'b0, cic_pkg::ADDR_CTRL, 32'h0);
    `CHK("enable back", 1'b1, rq[7])
    no_take();
    ilen <= 4'h6;
    apb(1'b1, cic_pkg::ADDR_CTRL, 32'hc0);
    take();
    apb(1'b1, cic_pkg::ADDR_PER_FLAG_BASE, 32'h01);
    ret();
    apb(1'b0, 8'hfc, 32'h0);
    `CHK("unmapped data", 32'h0, rq)
    `CHK("unmapped error", 1'b1, re)
    tally_and_finish();
  end
endmodule : tb_cpu_interrupt_controller
